// >>> sim/split_autoreload_timer_ctrl_bench.sv
// Testbench: register access, overflow, split, clock source and capture
`timescale 1ns/1ps
`default_nettype none
module split_autoreload_timer_ctrl_bench;
  // ********************
  // Stimulus and observed signals
  // ********************
  logic clk = 1'b0; // Core clock, 4 ns
  logic rstn = 1'b0; // Reset, active low
  logic sfr_wr = 1'b0; // Write strobe
  logic [7:0] sfr_addr = 8'h00; // Register address
  logic [7:0] sfr_wdata = 8'h00; // Write data
  logic timer_irq_enable = 1'b0; // Processor-side enable
  logic high_byte_clock_select = 1'b0; // 1 = core clock
  logic low_byte_clock_select = 1'b0; // 1 = core clock
  logic ext_clock = 1'b0; // External source, 20 ns period
  logic low_freq_oscillator = 1'b1; // Oscillator, 40 ns period
  logic [7:0] sfr_rdata; // Read data
  logic irq; // Interrupt request
  logic [7:0] counter_low_byte; // Count low byte
  logic [7:0] counter_high_byte; // Count high byte
  int n_errors = 0; // Mismatches
  int total_checks = 0; // Comparisons made
  logic [7:0] rd; // Last value read
  int gap; // Measured cycles between ticks
  int exp_gap [4] = '{12, 40, 0, 80}; // Per clock code; reserved gives none
  logic [7:0] addrs [6] = '{8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h90};
  // Device under test
  split_autoreload_timer_ctrl u_dut (
    .clk, .rstn, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata,
    .timer_irq_enable, .high_byte_clock_select, .low_byte_clock_select,
    .ext_clock, .low_freq_oscillator, .irq, .counter_low_byte,
    .counter_high_byte
  );
  // Core clock
  always #2 clk = ~clk;
  // Sources offset from core edges so sampling never ties
  initial begin
    #1;
    forever #10 ext_clock = ~ext_clock;
  end
  initial begin
    #3;
    forever #20 low_freq_oscillator = ~low_freq_oscillator;
  end
  // ********************
  // Access and checking tasks
  // ********************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle write strobe, launched and dropped at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  // Read mux is combinational, so sample just after the address settles
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    #1 d = sfr_rdata;
  endtask
  // Poll a control bit; bounded so a dead flag cannot hang the run
  task automatic wait_bit(input int b);
    int i;
    for (i = 0; i < 2000; i++) begin
      rd_reg(8'h91, rd);
      if (rd[b] === 1'b1) break;
    end
    if (i == 2000) check("flag wait", 16'h0, 16'h1);
  endtask
  function automatic logic [7:0] cur(input bit hi);
    return hi ? counter_high_byte : counter_low_byte;
  endfunction
  // Cycles between two count changes; 0 when none is seen
  task automatic measure(input bit hi, output int n);
    logic [7:0] v;
    int i;
    n = 0;
    v = cur(hi);
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (cur(hi) !== v) break;
    end
    if (i < 300) begin
      v = cur(hi);
      for (n = 1; n < 300; n++) begin
        @(negedge clk);
        if (cur(hi) !== v) break;
      end
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ********************
  // Test sequence
  // ********************
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    // Reset values, unmapped address reads zero
    foreach (addrs[k]) begin
      rd_reg(addrs[k], rd);
      check("reset value", rd, 16'h0);
    end
    // Read/write fields; code 10 keeps everything frozen
    wr(8'h91, 8'h2E);
    rd_reg(8'h91, rd);
    check("control", rd, 16'h2E);
    wr(8'h92, 8'hA5);
    wr(8'h93, 8'h5A);
    wr(8'h90, 8'hFF);
    rd_reg(8'h92, rd);
    check("reload low", rd, 16'hA5);
    rd_reg(8'h93, rd);
    check("reload high", rd, 16'h5A);
    rd_reg(8'h90, rd);
    check("unmapped", rd, 16'h0);
    timer_irq_enable = 1'b1;
    wr(8'h91, 8'hC2);
    check("irq on flag", irq, 16'h1);
    wr(8'h91, 8'h02);
    check("irq cleared", irq, 16'h0);
    // 16-bit wrap from FFF8 reloads 1234 and sets both flags
    low_byte_clock_select = 1'b1;
    wr(8'h92, 8'h34);
    wr(8'h93, 8'h12);
    wr(8'h94, 8'hF8);
    wr(8'h95, 8'hFF);
    rd_reg(8'h94, rd);
    check("stopped", rd, 16'hF8);
    wr(8'h91, 8'h04);
    @(negedge clk);
    rd = counter_low_byte;
    @(negedge clk);
    check("step", counter_low_byte - rd, 16'h1);
    wait_bit(7);
    check("wrap", {counter_high_byte, counter_low_byte}, 16'h1234);
    check("low flag", rd[6], 16'h1);
    check("irq wrap", irq, 16'h1);
    repeat (20) @(negedge clk);
    rd_reg(8'h91, rd);
    check("flags held", rd, 16'hC4);
    wr(8'h91, 8'h04);
    // Low rollover interrupts only with its own enable
    wait_bit(6);
    check("no low irq", irq, 16'h0);
    wr(8'h91, 8'h64);
    check("low irq", irq, 16'h1);
    // Split: low byte runs with run clear, high byte held
    wr(8'h91, 8'h0A);
    high_byte_clock_select = 1'b1;
    wr(8'h92, 8'hF0);
    wr(8'h93, 8'h80);
    wr(8'h95, 8'hFE);
    wr(8'h94, 8'hFA);
    wait_bit(6);
    check("split low reload", counter_low_byte, 16'hF0);
    check("high held", counter_high_byte, 16'hFE);
    check("no carry", rd[7], 16'h0);
    wr(8'h91, 8'h0E);
    wait_bit(7);
    check("split high reload", counter_high_byte, 16'h80);
    // Every alternate clock code on both split bytes
    high_byte_clock_select = 1'b0;
    low_byte_clock_select = 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(8'h91, 8'h0C | 8'(c));
      measure(1'b0, gap);
      check("low tick gap", 16'(gap), 16'(exp_gap[c]));
      measure(1'b1, gap);
      check("high tick gap", 16'(gap), 16'(exp_gap[c]));
    end
    // Oscillator capture of a stopped 16-bit count
    low_byte_clock_select = 1'b1;
    wr(8'h91, 8'h02);
    wr(8'h94, 8'hEF);
    wr(8'h95, 8'hBE);
    wr(8'h91, 8'h12);
    wait_bit(7);
    check("capture irq", irq, 16'h1);
    rd_reg(8'h92, rd);
    check("capture low", rd, 16'hEF);
    rd_reg(8'h93, rd);
    check("capture high", rd, 16'hBE);
    test_done();
  end
  // Watchdog: whole sequence needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule // split_autoreload_timer_ctrl_bench
`default_nettype wire

// >>> verilog/split_autoreload_timer_ctrl.sv
// Module: split 16/8-bit auto-reload timer with oscillator capture
// Summary of operation
// - High byte rollover sets high flag
// - 16-bit wrap sets high flag
// - High flag with irq enable requests interrupt
// - Low byte rollover sets low flag
// - Low flag set in every mode
// - Hardware never clears flags; software does
// - Low rollover interrupts when both enables set
// - Oscillator fall captures count, sets high flag, interrupts
// - Split bit picks 16-bit or dual 8-bit
// - Run gates counter; split low runs always
// - Alternate field: core/12, ext/8, reserved, osc/8
// - Divided sources synchronised to core clock
// - Alternate field shared by both split bytes
// - Reload low at 0x92, resets zero
// - Reload high at 0x93, resets zero
// - 16-bit wrap loads full reload value
// - Split bytes reload from their own byte
// - Byte clock select one uses core clock
`timescale 1ns/1ps
`default_nettype none
module split_autoreload_timer_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sfr_wr, // Special function write strobe
  input wire logic [7:0] sfr_addr, // Special function address
  input wire logic [7:0] sfr_wdata, // Write data
  output logic [7:0] sfr_rdata, // Read data, combinational mux
  input wire logic timer_irq_enable, // Processor-side enable
  input wire logic high_byte_clock_select, // 1 = core clock
  input wire logic low_byte_clock_select, // 1 = core clock
  input wire logic ext_clock, // External oscillator source
  input wire logic low_freq_oscillator, // Oscillator output
  output logic irq, // Interrupt request level
  output logic [7:0] counter_low_byte, // Count low byte
  output logic [7:0] counter_high_byte // Count high byte
);
  // ********************************************************
  // Clock sources
  // ********************************************************
  logic ext_tick; // External / 8, synchronised
  logic osc_tick; // Oscillator / 8, synchronised
  logic osc_fall; // Oscillator falling edge
  logic [3:0] pre_q, pre_d; // Core divide-by-12 prescaler
  logic core_div_tick; // Core / 12
  logic alt_tick; // Source chosen by alternate field
  logic lo_tick, hi_tick; // Per-byte ticks
  // No suspend state here, so both sources always go through
  // the synchroniser
  tick_source #(.DIV(split_timer_pkg::ALT_DIV)) u_ext (
    .clk(clk), .rstn(rstn), .src(ext_clock),
    .rise(), .fall(), .tick(ext_tick));
  tick_source #(.DIV(split_timer_pkg::ALT_DIV)) u_osc (
    .clk(clk), .rstn(rstn), .src(low_freq_oscillator),
    .rise(), .fall(osc_fall), .tick(osc_tick));
  // ********************************************************
  // Registers
  // ********************************************************
  logic [7:0] ctrl_q, ctrl_d; // Timer control
  logic [7:0] rl_lo_q, rl_lo_d; // Reload low byte
  logic [7:0] rl_hi_q, rl_hi_d; // Reload high byte
  logic [7:0] cnt_lo_q, cnt_lo_d; // Count low byte
  logic [7:0] cnt_hi_q, cnt_hi_d; // Count high byte
  logic split, run, lo_en, hi_en;
  logic lo_ovf, hi_ovf; // Rollover events this cycle
  logic [1:0] alt_sel;
  // Decode of the shared alternate clock field
  function automatic logic alt_pick(input logic [1:0] sel,
      input logic c12, input logic e8, input logic o8);
    case (sel)
      split_timer_pkg::CLK_CORE_DIV12: alt_pick = c12;
      split_timer_pkg::CLK_EXT_DIV8: alt_pick = e8;
      split_timer_pkg::CLK_OSC_DIV8: alt_pick = o8;
      default: alt_pick = 1'b0; // Reserved: bytes on the alternate source stall
    endcase
  endfunction
  assign alt_sel = ctrl_q[split_timer_pkg::BIT_ALT_CLK_HI -: 2];
  assign split = ctrl_q[split_timer_pkg::BIT_SPLIT];
  assign run = ctrl_q[split_timer_pkg::BIT_RUN];
  assign core_div_tick = (pre_q == 4'(split_timer_pkg::CORE_DIV - 1));
  assign alt_tick = alt_pick(alt_sel, core_div_tick, ext_tick,
                             osc_tick);
  // Both bytes share the alternate field, each picks core or alt
  assign lo_tick = low_byte_clock_select ? 1'b1 : alt_tick;
  // In 16-bit mode the low byte select drives the whole counter
  assign hi_tick = split ?
    (high_byte_clock_select ? 1'b1 : alt_tick) : lo_tick;
  // Split low byte free-runs; otherwise run gates both
  assign lo_en = lo_tick && (split || run);
  assign hi_en = split ? (hi_tick && run) : lo_en;
  assign lo_ovf = lo_en && (cnt_lo_q == split_timer_pkg::BYTE_ALL_ONES);
  // Unsplit, the high byte only moves on a low carry
  assign hi_ovf = hi_en && (cnt_hi_q == split_timer_pkg::BYTE_ALL_ONES)
                  && (split || lo_ovf);
  // Next-state for prescaler, counter, control and reloads
  always_comb begin
    pre_d = core_div_tick ? 4'h0 : 4'(pre_q + 4'h1);
    ctrl_d = ctrl_q;
    rl_lo_d = rl_lo_q;
    rl_hi_d = rl_hi_q;
    cnt_lo_d = cnt_lo_q;
    cnt_hi_d = cnt_hi_q;
    // Software writes first; hardware events below override
    if (sfr_wr) begin
      case (sfr_addr)
        split_timer_pkg::ADDR_TIMER_CONTROL: ctrl_d = sfr_wdata;
        split_timer_pkg::ADDR_RELOAD_LOW: rl_lo_d = sfr_wdata;
        split_timer_pkg::ADDR_RELOAD_HIGH: rl_hi_d = sfr_wdata;
        split_timer_pkg::ADDR_COUNTER_LOW: cnt_lo_d = sfr_wdata;
        split_timer_pkg::ADDR_COUNTER_HIGH: cnt_hi_d = sfr_wdata;
        default: ; // Unmapped: ignored
      endcase
    end
    // Counting: a tick beats a same-cycle software count write
    if (split) begin
      if (lo_en) begin
        cnt_lo_d = lo_ovf ? rl_lo_q : 8'(cnt_lo_q + 8'h01);
      end
      if (hi_en) begin
        cnt_hi_d = hi_ovf ? rl_hi_q : 8'(cnt_hi_q + 8'h01);
      end
    end else if (lo_en) begin
      if (hi_ovf) begin
        cnt_lo_d = rl_lo_q;
        cnt_hi_d = rl_hi_q;
      end else begin
        cnt_lo_d = 8'(cnt_lo_q + 8'h01);
        if (lo_ovf) begin
          cnt_hi_d = 8'(cnt_hi_q + 8'h01);
        end
      end
    end
    // Flag sets win over a same-cycle clear; only software clears
    if (lo_ovf) begin
      ctrl_d[split_timer_pkg::BIT_LOW_FLAG] = 1'b1;
    end
    if (hi_ovf) begin
      ctrl_d[split_timer_pkg::BIT_HIGH_FLAG] = 1'b1;
    end
    // Capture copies the live count, not the post-tick value
    if (ctrl_q[split_timer_pkg::BIT_CAPTURE_EN] && osc_fall) begin
      rl_lo_d = cnt_lo_q;
      rl_hi_d = cnt_hi_q;
      ctrl_d[split_timer_pkg::BIT_HIGH_FLAG] = 1'b1;
    end
  end
  // Register stage, synchronous reset to zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_q <= 4'h0;
      ctrl_q <= split_timer_pkg::RESET_BYTE;
      rl_lo_q <= split_timer_pkg::RESET_BYTE;
      rl_hi_q <= split_timer_pkg::RESET_BYTE;
      cnt_lo_q <= split_timer_pkg::RESET_BYTE;
      cnt_hi_q <= split_timer_pkg::RESET_BYTE;
    end else begin
      pre_q <= pre_d;
      ctrl_q <= ctrl_d;
      rl_lo_q <= rl_lo_d;
      rl_hi_q <= rl_hi_d;
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
    end
  end
  // ********************************************************
  // Read mux and interrupt
  // ********************************************************
  always_comb begin
    case (sfr_addr)
      split_timer_pkg::ADDR_TIMER_CONTROL: sfr_rdata = ctrl_q;
      split_timer_pkg::ADDR_RELOAD_LOW: sfr_rdata = rl_lo_q;
      split_timer_pkg::ADDR_RELOAD_HIGH: sfr_rdata = rl_hi_q;
      split_timer_pkg::ADDR_COUNTER_LOW: sfr_rdata = cnt_lo_q;
      split_timer_pkg::ADDR_COUNTER_HIGH: sfr_rdata = cnt_hi_q;
      default: sfr_rdata = 8'h00;
    endcase
  end
  // Level request; the flag is the pending state
  assign irq = timer_irq_enable &&
    (ctrl_q[split_timer_pkg::BIT_HIGH_FLAG] ||
     (ctrl_q[split_timer_pkg::BIT_LOW_FLAG] &&
      ctrl_q[split_timer_pkg::BIT_LOW_IRQ_EN]));
  assign counter_low_byte = cnt_lo_q;
  assign counter_high_byte = cnt_hi_q;
  // ********************************************************
  // Assertions
  // ********************************************************
  property p_high_flag_set;
    @(posedge clk) disable iff (!rstn) hi_ovf |=> ctrl_q[7];
  endproperty
  a_high_flag_set: assert property (p_high_flag_set)
    else $error("high flag not set after high rollover");
  property p_wrap16;
    @(posedge clk) disable iff (!rstn)
      (!split && lo_en && cnt_lo_q == 8'hFF && cnt_hi_q == 8'hFF)
      |=> ctrl_q[7];
  endproperty
  a_wrap16: assert property (p_wrap16)
    else $error("16-bit wrap did not set high flag");
  property p_irq_high;
    @(posedge clk) disable iff (!rstn)
      (ctrl_q[7] && timer_irq_enable) |-> irq;
  endproperty
  a_irq_high: assert property (p_irq_high)
    else $error("no interrupt with high flag set");
  property p_low_flag;
    @(posedge clk) disable iff (!rstn) lo_ovf |=> ctrl_q[6];
  endproperty
  a_low_flag: assert property (p_low_flag)
    else $error("low flag not set after low rollover");
  property p_no_hw_clear;
    @(posedge clk) disable iff (!rstn)
      (ctrl_q[7:6] != 2'h0 &&
       !(sfr_wr && sfr_addr == 8'h91))
      |=> (ctrl_q[7:6] & $past(ctrl_q[7:6])) == $past(ctrl_q[7:6]);
  endproperty
  a_no_hw_clear: assert property (p_no_hw_clear)
    else $error("overflow flag cleared without software write");
  property p_irq_low;
    @(posedge clk) disable iff (!rstn)
      lo_ovf |=> (!timer_irq_enable ||
                  !ctrl_q[split_timer_pkg::BIT_LOW_IRQ_EN] || irq);
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("no interrupt after low rollover");
  property p_capture;
    @(posedge clk) disable iff (!rstn)
      (ctrl_q[4] && osc_fall) |=>
      (rl_lo_q == $past(cnt_lo_q) && rl_hi_q == $past(cnt_hi_q)
       && ctrl_q[7]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not copy count");
  property p_run_gate;
    @(posedge clk) disable iff (!rstn)
      (!split && !run && !(sfr_wr && sfr_addr[7:1] == 7'h4A))
      |=> $stable(cnt_lo_q) && $stable(cnt_hi_q);
  endproperty
  a_run_gate: assert property (p_run_gate)
    else $error("counter moved while stopped");
  property p_reload16;
    @(posedge clk) disable iff (!rstn)
      (!split && hi_ovf) |=>
      cnt_lo_q == $past(rl_lo_q) && cnt_hi_q == $past(rl_hi_q);
  endproperty
  a_reload16: assert property (p_reload16)
    else $error("16-bit reload value not loaded");
  property p_step;
    @(posedge clk) disable iff (!rstn)
      (lo_en && !lo_ovf && !(sfr_wr && sfr_addr == 8'h94))
      |=> cnt_lo_q == 8'($past(cnt_lo_q) + 8'h01);
  endproperty
  a_step: assert property (p_step)
    else $error("low count did not step by one");
  // Low flag in 16-bit mode, judged from the raw count, not lo_ovf
  property p_low_flag_wide;
    @(posedge clk) disable iff (!rstn)
      (!split && lo_en && cnt_lo_q == split_timer_pkg::BYTE_ALL_ONES)
      |=> ctrl_q[split_timer_pkg::BIT_LOW_FLAG];
  endproperty
  a_low_flag_wide: assert property (p_low_flag_wide)
    else $error("low flag not set on 16-bit low carry");
  // ********************************************************
  // Split mode assertions
  // ********************************************************
  // Split low byte steps even with run clear
  property p_split_low_free;
    @(posedge clk) disable iff (!rstn)
      (split && lo_tick && cnt_lo_q != split_timer_pkg::BYTE_ALL_ONES)
      |=> cnt_lo_q == 8'($past(cnt_lo_q) + 8'h01);
  endproperty
  a_split_low_free: assert property (p_split_low_free)
    else $error("split low byte did not free-run");
  // Split high byte holds while stopped, bar a direct write
  property p_split_high_hold;
    @(posedge clk) disable iff (!rstn)
      (split && !run &&
       !(sfr_wr && sfr_addr == split_timer_pkg::ADDR_COUNTER_HIGH))
      |=> $stable(cnt_hi_q);
  endproperty
  a_split_high_hold: assert property (p_split_high_hold)
    else $error("split high byte moved while stopped");
  // Split high byte reloads from its own reload byte
  property p_reload8_high;
    @(posedge clk) disable iff (!rstn)
      (split && hi_ovf) |=> cnt_hi_q == $past(rl_hi_q);
  endproperty
  a_reload8_high: assert property (p_reload8_high)
    else $error("split high byte reload value not loaded");
  c_wrap16: cover property (@(posedge clk) disable iff (!rstn)
    !split && hi_ovf);
  c_split_both: cover property (@(posedge clk) disable iff (!rstn)
    split && lo_ovf ##[1:600] hi_ovf);
  c_capture: cover property (@(posedge clk) disable iff (!rstn)
    ctrl_q[4] && osc_fall);
  c_split_low_free: cover property (@(posedge clk) disable iff (!rstn)
    split && !run && lo_ovf);
  c_low_irq: cover property (@(posedge clk) disable iff (!rstn)
    lo_ovf && ctrl_q[split_timer_pkg::BIT_LOW_IRQ_EN] && timer_irq_enable);
endmodule // split_autoreload_timer_ctrl
`default_nettype wire

// >>> verilog/split_timer_pkg.sv
// Package: addresses, field positions, reset values and clock codes
`default_nettype none
package split_timer_pkg;
  // ********************************************************
  // Special function addresses
  // ********************************************************
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h91; // Control
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92; // Reload low byte
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93; // Reload high byte
  localparam logic [7:0] ADDR_COUNTER_LOW = 8'h94; // Count low byte
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h95; // Count high byte
  // ********************************************************
  // Control field positions
  // ********************************************************
  localparam int BIT_HIGH_FLAG = 7; // High overflow flag
  localparam int BIT_LOW_FLAG = 6; // Low overflow flag
  localparam int BIT_LOW_IRQ_EN = 5; // Low overflow irq enable
  localparam int BIT_CAPTURE_EN = 4; // Oscillator capture enable
  localparam int BIT_SPLIT = 3; // Split mode select
  localparam int BIT_RUN = 2; // Run control
  localparam int BIT_ALT_CLK_HI = 1; // Alternate clock field top
  // ********************************************************
  // Reset values and constants
  // ********************************************************
  localparam logic [7:0] RESET_BYTE = 8'h00; // All registers
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF; // Rollover point
  localparam int CORE_DIV = 12; // Core clock divide
  localparam int ALT_DIV = 8; // External and oscillator divide
  localparam logic [1:0] CLK_CORE_DIV12 = 2'h0; // Core / 12
  localparam logic [1:0] CLK_EXT_DIV8 = 2'h1; // External / 8
  localparam logic [1:0] CLK_RESERVED = 2'h2; // No ticks
  localparam logic [1:0] CLK_OSC_DIV8 = 2'h3; // Oscillator / 8
endpackage
`default_nettype wire

// >>> verilog/tick_source.sv
// Module: tick generator with synchronised edge divider
`timescale 1ns/1ps
`default_nettype none
module tick_source #(
  parameter int DIV = 8 // Rising edges per output tick
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic src, // Asynchronous source clock
  output logic rise, // One pulse per source rising edge
  output logic fall, // One pulse per source falling edge
  output logic tick // One pulse per DIV rising edges
);
  // ********************************************************
  // Synchroniser and divider
  // ********************************************************
  logic s1_q, s1_d; // First stage, read only by s2
  logic s2_q, s2_d; // Second stage
  logic s3_q, s3_d; // Edge history
  logic [3:0] cnt_q, cnt_d; // Divider count
  // Next-state: the edge detector looks at s2 and s3 only
  always_comb begin
    s1_d = src;
    s2_d = s1_q;
    s3_d = s2_q;
    cnt_d = cnt_q;
    if (s2_q && !s3_q) begin
      cnt_d = (cnt_q == 4'(DIV - 1)) ? 4'h0 : 4'(cnt_q + 4'h1);
    end
  end
  // Register stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      cnt_q <= cnt_d;
    end
  end
  assign rise = s2_q && !s3_q;
  assign fall = !s2_q && s3_q;
  assign tick = rise && (cnt_q == 4'(DIV - 1));
endmodule // tick_source
`default_nettype wire
